// >>> rtl/ivt_vector_table.sv
// How it works
// - any system reset fetches from slot zero of the reset base
// - external requests zero, one at 0x001, 0x002
// - pin-change groups 0x003-0x005, watchdog 0x006
// - second byte timer events at 0x007-0x009
// - wide timer events at 0x00A-0x00D
// - first byte timer events at 0x00E-0x010
// - serial and usart events at 0x011-0x014
// - converter, eeprom, comparator, two-wire, store 0x015-0x019
// - small variants use one-word vector slots
// - large variants use two-word vector slots
// - smallest variant ignores all boot selection
// - boot fuse selects reset target in boot variants
// - vector select bit selects vector base
// - selected vectors sit at boot start plus offset
// - programmed fuse (low) resets to boot address
`timescale 1ns/1ps
`include "ivt_defines.svh"

module ivt_vector_table #(
	parameter ivt_pkg::ivt_variant_t VARIANT         = ivt_pkg::IVT_VAR_32K,
	parameter int unsigned           PC_W            = `IVT_PC_W,
	parameter logic [PC_W-1:0]       BOOT_RESET_ADDR = `IVT_BOOT_RESET_ADDR
) (
	// clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     rst_n,
	// reset causes and boot configuration
	input  ivt_pkg::ivt_reset_cause_t     resetCause,
	input  wire logic                     bootResetSelectFuseN,
	input  wire logic                     vectorBaseSelectBit,
	// interrupt requests, already enabled
	input  ivt_pkg::ivt_src_t             irqSource,
	// core handshake
	input  wire logic                     coreTakeIrq,
	output ivt_pkg::ivt_fetch_t           fetch,
	output logic [PC_W-1:0]               fetchAddr,
	output logic [`IVT_NUM_SRC-1:0]       irqAck,
	output logic                          busy,
	// table lookup
	input  wire logic [`IVT_SLOT_W-1:0]   querySlot,
	output logic [PC_W-1:0]               queryAddr
);
	import ivt_pkg::*;

	function automatic logic [`IVT_NUM_SRC-1:0] srcVector(input ivt_src_t s);
		logic [`IVT_NUM_SRC-1:0] v;
		v = '0;
		v[`IVT_SLOT_EXT0 - 1]       = s.externalRequestZero;
		v[`IVT_SLOT_EXT1 - 1]       = s.externalRequestOne;
		v[`IVT_SLOT_PCG0 - 1]       = s.pinChangeGroupZero;
		v[`IVT_SLOT_PCG1 - 1]       = s.pinChangeGroupOne;
		v[`IVT_SLOT_PCG2 - 1]       = s.pinChangeGroupTwo;
		v[`IVT_SLOT_WDOG - 1]       = s.watchdogTimeoutSource;
		v[`IVT_SLOT_T2_CMPA - 1]    = s.secondByteTimerCompareA;
		v[`IVT_SLOT_T2_CMPB - 1]    = s.secondByteTimerCompareB;
		v[`IVT_SLOT_T2_OVF - 1]     = s.secondByteTimerOverflow;
		v[`IVT_SLOT_T1_CAPT - 1]    = s.wideTimerCapture;
		v[`IVT_SLOT_T1_CMPA - 1]    = s.wideTimerCompareA;
		v[`IVT_SLOT_T1_CMPB - 1]    = s.wideTimerCompareB;
		v[`IVT_SLOT_T1_OVF - 1]     = s.wideTimerOverflow;
		v[`IVT_SLOT_T0_CMPA - 1]    = s.firstByteTimerCompareA;
		v[`IVT_SLOT_T0_CMPB - 1]    = s.firstByteTimerCompareB;
		v[`IVT_SLOT_T0_OVF - 1]     = s.firstByteTimerOverflow;
		v[`IVT_SLOT_SPI_DONE - 1]   = s.spiTransferDone;
		v[`IVT_SLOT_USART_RX - 1]   = s.usartRxDone;
		v[`IVT_SLOT_USART_TX_BUFFER_EMPTY - 1] = s.usartTxBufferEmpty;
		v[`IVT_SLOT_USART_TX - 1]   = s.usartTxDone;
		v[`IVT_SLOT_ADC_DONE - 1]   = s.converterDone;
		v[`IVT_SLOT_EEPROM_READY_SOURCE - 1]   = s.eepromReadySource;
		v[`IVT_SLOT_ACOMP - 1]      = s.analogComparator;
		v[`IVT_SLOT_TWOWIRE - 1]    = s.twoWireSerialSource;
		v[`IVT_SLOT_STORE_RDY - 1]  = s.programStoreReady;
		return v;
	endfunction

	// base plus slot times slot size in words
	function automatic logic [PC_W-1:0] slotAddr(
		input logic [PC_W-1:0]        base,
		input logic [`IVT_SLOT_W-1:0] slot,
		input logic                   twoWord
	);
		logic [PC_W-1:0] offset;
		offset = twoWord ? PC_W'({slot, 1'b0}) : PC_W'(slot);
		return PC_W'(base + offset);
	endfunction

	// variant decode
	localparam logic HAS_BOOT = (VARIANT != IVT_VAR_4K);
	localparam logic TWO_WORD = (VARIANT == IVT_VAR_16K) || (VARIANT == IVT_VAR_32K);

	ivt_state_t              state;
	ivt_state_t              next_state;
	logic                    fuseProgrammed;
	logic [`IVT_SLOT_W-1:0]  grantSlot;
	logic [`IVT_NUM_SRC-1:0] grantOneHot;

	wire logic                    anyResetCause;
	wire logic [`IVT_NUM_SRC-1:0] pending;
	wire logic                    pendValid;
	wire logic [`IVT_SLOT_W-1:0]  pendSlot;
	wire logic [`IVT_NUM_SRC-1:0] pendOneHot;
	wire logic                    bootReset;
	wire logic                    bootVectors;
	wire logic [PC_W-1:0]         resetBase;
	wire logic [PC_W-1:0]         vectorBase;
	wire logic [PC_W-1:0]         resetTarget;
	wire logic [PC_W-1:0]         irqTarget;
	wire logic                    acceptIrq;

	assign anyResetCause = |resetCause;
	assign pending       = srcVector(irqSource);

	ivt_prio_enc #(
		.N(`IVT_NUM_SRC)
	) u_prio (
		.req  (pending),
		.valid(pendValid),
		.slot (pendSlot),
		.grant(pendOneHot)
	);

	// smallest variant never moves its reset or vectors
	assign bootReset   = HAS_BOOT && fuseProgrammed;
	assign bootVectors = HAS_BOOT && vectorBaseSelectBit;
	assign resetBase   = bootReset ? BOOT_RESET_ADDR : PC_W'(`IVT_APP_RESET_ADDR);
	assign vectorBase  = bootVectors ? BOOT_RESET_ADDR : PC_W'(`IVT_APP_RESET_ADDR);
	assign resetTarget = slotAddr(resetBase, `IVT_SLOT_RESET, TWO_WORD);
	assign irqTarget   = slotAddr(vectorBase, grantSlot, TWO_WORD);
	assign acceptIrq   = coreTakeIrq && pendValid;

	always_comb begin
		next_state = state;
		case (state)
			IVT_ST_BOOT: begin
				next_state = IVT_ST_RESET_FETCH;
			end
			IVT_ST_RESET_FETCH: begin
				next_state = IVT_ST_IDLE;
			end
			IVT_ST_IDLE: begin
				if (acceptIrq) begin
					next_state = IVT_ST_IRQ_FETCH;
				end
			end
			IVT_ST_IRQ_FETCH: begin
				next_state = IVT_ST_GAP;
			end
			IVT_ST_GAP: begin
				// wait for the core to drop its take request
				if (!coreTakeIrq) begin
					next_state = IVT_ST_IDLE;
				end
			end
			default: begin
				next_state = IVT_ST_BOOT;
			end
		endcase
		// a system reset cause overrides everything
		if (anyResetCause) begin
			next_state = IVT_ST_BOOT;
		end
	end

	wire logic        next_fetchStrobe;
	wire logic        next_fetchIsReset;
	wire logic        next_busy;

	assign next_fetchStrobe  = (state == IVT_ST_RESET_FETCH || state == IVT_ST_IRQ_FETCH)
		&& !anyResetCause;
	assign next_fetchIsReset = (state == IVT_ST_RESET_FETCH);
	assign next_busy         = (next_state != IVT_ST_IDLE);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= IVT_ST_BOOT;
		end else begin
			state <= next_state;
		end
	end

	// fuse caught while booting, after reset release
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fuseProgrammed <= 1'b0;
		end else if (state == IVT_ST_BOOT) begin
			fuseProgrammed <= !bootResetSelectFuseN;
		end
	end

	// winner frozen at acceptance
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			grantSlot   <= '0;
			grantOneHot <= '0;
		end else if (state == IVT_ST_IDLE && acceptIrq) begin
			grantSlot   <= pendSlot;
			grantOneHot <= pendOneHot;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fetch     <= '0;
			fetchAddr <= '0;
			irqAck    <= '0;
			busy      <= 1'b1;
		end else begin
			fetch.strobe  <= next_fetchStrobe;
			fetch.isReset <= next_fetchIsReset;
			fetch.slot    <= next_fetchIsReset ? `IVT_SLOT_RESET : grantSlot;
			if (next_fetchStrobe) begin
				fetchAddr <= next_fetchIsReset ? resetTarget : irqTarget;
			end
			irqAck <= (next_fetchStrobe && !next_fetchIsReset) ? grantOneHot : '0;
			busy   <= next_busy;
		end
	end

	// lookup uses the live vector base
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			queryAddr <= '0;
		end else if (querySlot == `IVT_SLOT_RESET) begin
			queryAddr <= resetTarget;
		end else begin
			queryAddr <= slotAddr(vectorBase, querySlot, TWO_WORD);
		end
	end

endmodule // ivt_vector_table

// >>> rtl/ivt_defines.svh
`ifndef IVT_DEFINES_SVH
`define IVT_DEFINES_SVH

// program counter width in instruction words
`define IVT_PC_W            14
`define IVT_NUM_SRC         25
`define IVT_SLOT_W          5

// slot indices, scaled by the slot size to get word addresses
`define IVT_SLOT_RESET      5'h00
`define IVT_SLOT_EXT0       5'h01
`define IVT_SLOT_EXT1       5'h02
`define IVT_SLOT_PCG0       5'h03
`define IVT_SLOT_PCG1       5'h04
`define IVT_SLOT_PCG2       5'h05
`define IVT_SLOT_WDOG       5'h06
`define IVT_SLOT_T2_CMPA    5'h07
`define IVT_SLOT_T2_CMPB    5'h08
`define IVT_SLOT_T2_OVF     5'h09
`define IVT_SLOT_T1_CAPT    5'h0A
`define IVT_SLOT_T1_CMPA    5'h0B
`define IVT_SLOT_T1_CMPB    5'h0C
`define IVT_SLOT_T1_OVF     5'h0D
`define IVT_SLOT_T0_CMPA    5'h0E
`define IVT_SLOT_T0_CMPB    5'h0F
`define IVT_SLOT_T0_OVF     5'h10
`define IVT_SLOT_SPI_DONE   5'h11
`define IVT_SLOT_USART_RX   5'h12
`define IVT_SLOT_USART_TX_BUFFER_EMPTY 5'h13
`define IVT_SLOT_USART_TX   5'h14
`define IVT_SLOT_ADC_DONE   5'h15
`define IVT_SLOT_EEPROM_READY_SOURCE   5'h16
`define IVT_SLOT_ACOMP      5'h17
`define IVT_SLOT_TWOWIRE    5'h18
`define IVT_SLOT_STORE_RDY  5'h19

// application reset address
`define IVT_APP_RESET_ADDR  14'h0000
// boot section start, plain default, sized by the boot size fuses elsewhere
`define IVT_BOOT_RESET_ADDR 14'h3800

`endif

// >>> rtl/ivt_pkg.sv
`include "ivt_defines.svh"

package ivt_pkg;

	typedef enum logic [1:0] {
		IVT_VAR_4K  = 2'h0,
		IVT_VAR_8K  = 2'h1,
		IVT_VAR_16K = 2'h2,
		IVT_VAR_32K = 2'h3
	} ivt_variant_t;

	typedef enum logic [4:0] {
		IVT_ST_BOOT        = 5'h01,
		IVT_ST_RESET_FETCH = 5'h02,
		IVT_ST_IDLE        = 5'h04,
		IVT_ST_IRQ_FETCH   = 5'h08,
		IVT_ST_GAP         = 5'h10
	} ivt_state_t;

	typedef struct packed {
		logic externalPin;
		logic powerOn;
		logic brownOut;
		logic watchdogSystem;
	} ivt_reset_cause_t;

	typedef struct packed {
		logic externalRequestZero;
		logic externalRequestOne;
		logic pinChangeGroupZero;
		logic pinChangeGroupOne;
		logic pinChangeGroupTwo;
		logic watchdogTimeoutSource;
		logic secondByteTimerCompareA;
		logic secondByteTimerCompareB;
		logic secondByteTimerOverflow;
		logic wideTimerCapture;
		logic wideTimerCompareA;
		logic wideTimerCompareB;
		logic wideTimerOverflow;
		logic firstByteTimerCompareA;
		logic firstByteTimerCompareB;
		logic firstByteTimerOverflow;
		logic spiTransferDone;
		logic usartRxDone;
		logic usartTxBufferEmpty;
		logic usartTxDone;
		logic converterDone;
		logic eepromReadySource;
		logic analogComparator;
		logic twoWireSerialSource;
		logic programStoreReady;
	} ivt_src_t;

	typedef struct packed {
		logic                   strobe;
		logic                   isReset;
		logic [`IVT_SLOT_W-1:0] slot;
	} ivt_fetch_t;

endpackage : ivt_pkg

// >>> rtl/ivt_prio_enc.sv
`timescale 1ns/1ps
`include "ivt_defines.svh"

module ivt_prio_enc #(
	parameter int unsigned N = `IVT_NUM_SRC
) (
	// pending requests, bit i is slot i+1
	input  wire logic [N-1:0]           req,
	// winner
	output wire logic                   valid,
	output wire logic [`IVT_SLOT_W-1:0] slot,
	output wire logic [N-1:0]           grant
);
	import ivt_pkg::*;

	// lowest bit wins, so the lowest vector address is served first
	function automatic logic [`IVT_SLOT_W-1:0] lowestSlot(input logic [N-1:0] r);
		logic [`IVT_SLOT_W-1:0] s;
		s = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (r[i]) begin
				s = `IVT_SLOT_W'(i + 1);
			end
		end
		return s;
	endfunction

	wire logic [N-1:0] lowestOneHot;

	assign lowestOneHot = req & ~(req - N'(1));
	assign valid        = |req;
	assign slot         = lowestSlot(req);
	assign grant        = lowestOneHot;

endmodule // ivt_prio_enc

// >>> verif/ivt_properties.sv
`timescale 1ns/1ps
module ivt_properties #(
	parameter ivt_pkg::ivt_variant_t VARIANT         = ivt_pkg::IVT_VAR_32K,
	parameter int unsigned           PC_W            = 14,
	parameter logic [PC_W-1:0]       BOOT_RESET_ADDR = 14'h3800
) (
	// clock and reset
	input wire logic                 ref_clk,
	input wire logic                 rst_n,
	// causes, configuration, requests
	input ivt_pkg::ivt_reset_cause_t resetCause,
	input wire logic                 bootResetSelectFuseN,
	input wire logic                 vectorBaseSelectBit,
	input ivt_pkg::ivt_src_t         irqSource,
	input wire logic                 coreTakeIrq,
	// fetch side
	input ivt_pkg::ivt_fetch_t       fetch,
	input wire logic [PC_W-1:0]      fetchAddr,
	input wire logic [24:0]          irqAck,
	input wire logic                 busy,
	// lookup
	input wire logic [4:0]           querySlot,
	input wire logic [PC_W-1:0]      queryAddr
);
	import ivt_pkg::*;
	localparam int SZ = (VARIANT == IVT_VAR_4K || VARIANT == IVT_VAR_8K) ? 1 : 2;
	localparam bit HB = VARIANT != IVT_VAR_4K;
	logic [PC_W-1:0] base;
	logic [PC_W-1:0] qExp;
	logic [PC_W-1:0] rstExp;
	logic [24:0]     srcBits;
	logic [4:0]      low;
	assign base = (HB && vectorBaseSelectBit) ? BOOT_RESET_ADDR : '0;
	// slot zero looks up the reset target, not a vector
	assign qExp = (querySlot == 5'h00) ? rstExp : base + PC_W'(querySlot) * PC_W'(SZ);
	assign rstExp = (HB && !bootResetSelectFuseN) ? BOOT_RESET_ADDR : '0;
	assign srcBits = irqSource;
	// lowest pending slot, slot 1 sits at the top bit
	always_comb begin
		low = '0;
		for (int k = 0; k < 25; k++) begin
			if (srcBits[k])
				low = 5'(25 - k);
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_pulse; fetch.strobe |=> !fetch.strobe; endproperty
	a_pulse: assert property (p_pulse)
		else $error("fetch strobe longer than one cycle");
	property p_noack; !fetch.strobe |-> irqAck == '0; endproperty
	a_noack: assert property (p_noack)
		else $error("acknowledge without strobe");
	property p_ack;
		fetch.strobe && !fetch.isReset |-> irqAck == (25'h1 << (fetch.slot - 5'h01));
	endproperty
	a_ack: assert property (p_ack)
		else $error("acknowledge does not match slot");
	property p_low;
		!busy && coreTakeIrq && (|srcBits) && resetCause == '0
			|-> ##2 (fetch.strobe && fetch.slot == $past(low, 2));
	endproperty
	a_low: assert property (p_low)
		else $error("wrong source served");
	property p_rst;
		(resetCause != '0) ##1 (resetCause == '0)
			|-> ##[1:3] (fetch.strobe && fetch.isReset && fetchAddr == rstExp);
	endproperty
	a_rst: assert property (p_rst)
		else $error("reset fetch missing or wrong address");
	property p_irqaddr;
		fetch.strobe && !fetch.isReset
			|-> fetchAddr == $past(base) + PC_W'(fetch.slot) * PC_W'(SZ);
	endproperty
	a_irqaddr: assert property (p_irqaddr)
		else $error("interrupt fetch address wrong");
	property p_query; $past(rst_n) |-> queryAddr == $past(qExp); endproperty
	a_query: assert property (p_query)
		else $error("lookup address wrong");
	property p_hold; !fetch.strobe |-> $stable(fetchAddr); endproperty
	a_hold: assert property (p_hold)
		else $error("fetch address moved without strobe");
	c_reset: cover property (fetch.strobe && fetch.isReset);
	c_boot: cover property (fetch.strobe && !fetch.isReset && fetchAddr >= BOOT_RESET_ADDR);
	c_two: cover property ($countones(srcBits) > 1 && coreTakeIrq && !busy);
endmodule // ivt_properties

bind ivt_vector_table ivt_properties #(
	.VARIANT(VARIANT), .PC_W(PC_W), .BOOT_RESET_ADDR(BOOT_RESET_ADDR)
) chk_u (
	.ref_clk(ref_clk), .rst_n(rst_n), .resetCause(resetCause),
	.bootResetSelectFuseN(bootResetSelectFuseN), .vectorBaseSelectBit(vectorBaseSelectBit),
	.irqSource(irqSource), .coreTakeIrq(coreTakeIrq), .fetch(fetch), .fetchAddr(fetchAddr),
	.irqAck(irqAck), .busy(busy), .querySlot(querySlot), .queryAddr(queryAddr)
);

// >>> verif/ivt_core_model.sv
`timescale 1ns/1ps
module ivt_core_model (
	// clock and reset
	input wire logic           ref_clk,
	input wire logic           rst_n,
	// bench control
	input wire logic           enable,
	input wire logic [3:0]     stall,
	// block side
	input ivt_pkg::ivt_fetch_t fetch,
	output logic               coreTakeIrq
);
	import ivt_pkg::*;
	logic [3:0] holdCnt;
	// drops the take after each fetch, slow cores keep it low longer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			coreTakeIrq <= 1'b0;
			holdCnt <= 4'h0;
		end else if (fetch.strobe) begin
			coreTakeIrq <= 1'b0;
			holdCnt <= stall;
		end else if (holdCnt != 4'h0) begin
			holdCnt <= holdCnt - 4'h1;
		end else begin
			coreTakeIrq <= enable;
		end
	end
endmodule // ivt_core_model

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin fails++; \
	$display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module tb_top;
	import ivt_pkg::*;
	localparam logic [13:0] BA = 14'h3800;
	localparam ivt_variant_t VARS [4] = '{IVT_VAR_4K, IVT_VAR_8K, IVT_VAR_32K, IVT_VAR_16K};
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  cause = 4'h0;
	logic        fuseN = 1'b1;
	logic        vsel = 1'b0;
	logic        coreEn = 1'b0;
	logic [3:0]  stall = 4'h0;
	logic [24:0] src = 25'h000_0000;
	logic [4:0]  qSlot = 5'h01;
	ivt_src_t    irqSrc;
	logic        take;
	ivt_fetch_t  fetch [4];
	logic [13:0] addr [4];
	logic [13:0] qa [4];
	logic [24:0] ack [4];
	logic        busy [4];
	int          fails = 0;
	int          tests_run = 0;
	always #5 ref_clk = ~ref_clk;
	always_comb for (int k = 0; k < 25; k++) irqSrc[24 - k] = src[k];
	for (genvar v = 0; v < 4; v++) begin : g
		ivt_vector_table #(.VARIANT(VARS[v]), .BOOT_RESET_ADDR(BA)) dut_u (
			.ref_clk(ref_clk), .rst_n(rst_n), .resetCause(ivt_reset_cause_t'(cause)),
			.bootResetSelectFuseN(fuseN), .vectorBaseSelectBit(vsel), .irqSource(irqSrc),
			.coreTakeIrq(take), .fetch(fetch[v]), .fetchAddr(addr[v]), .irqAck(ack[v]),
			.busy(busy[v]), .querySlot(qSlot), .queryAddr(qa[v]));
	end
	ivt_core_model core_u (.ref_clk(ref_clk), .rst_n(rst_n), .enable(coreEn),
		.stall(stall), .fetch(fetch[2]), .coreTakeIrq(take));
	function automatic logic [13:0] expA(int v, logic s, logic [4:0] n);
		// two-word slots in the two larger variants
		expA = ((v != 0 && s) ? BA : 14'h0000) + 14'(n) * ((v >= 2) ? 14'h0002 : 14'h0001);
	endfunction
	task automatic waitStrobe();
		@(posedge ref_clk);
		#1;
		repeat (20) if (fetch[2].strobe !== 1'b1) begin
			@(posedge ref_clk);
			#1;
		end
		`CHK("strobe", 1'b1, fetch[2].strobe)
	endtask
	task automatic t_table();
		for (int s = 0; s < 2; s++) begin
			for (int n = 1; n < 26; n++) begin
				@(posedge ref_clk);
				vsel <= s[0];
				qSlot <= 5'(n);
				repeat (2) @(posedge ref_clk);
				#1;
				for (int v = 0; v < 4; v++) `CHK("query", expA(v, s[0], 5'(n)), qa[v])
			end
		end
		$display("table test done");
	endtask
	task automatic t_reset();
		for (int f = 0; f < 2; f++) begin
			for (int c = 0; c < 4; c++) begin
				@(posedge ref_clk);
				fuseN <= f[0];
				cause <= 4'h1 << c;
				@(posedge ref_clk);
				cause <= 4'h0;
				waitStrobe();
				for (int v = 0; v < 4; v++) `CHK("reset", (v != 0 && !f[0]) ? BA : 14'h0000, addr[v])
				`CHK("isReset", 1'b1, fetch[2].isReset)
			end
		end
		$display("reset test done");
	endtask
	task automatic t_irq(input logic [3:0] st);
		logic sv;
		@(posedge ref_clk);
		stall <= st;
		src <= 25'h100_0001;
		repeat (4) @(posedge ref_clk);
		#1;
		`CHK("refused", 1'b0, fetch[2].strobe)
		@(posedge ref_clk);
		coreEn <= 1'b1;
		sv = vsel;
		for (int n = 1; n < 26; n++) begin
			waitStrobe();
			`CHK("slot", 5'(n), fetch[2].slot)
			for (int v = 0; v < 4; v++) `CHK("vector", expA(v, sv, 5'(n)), addr[v])
			`CHK("ack", 25'h1 << (n - 1), ack[2])
			`CHK("busy", 1'b1, busy[2])
			@(posedge ref_clk);
			sv = ~sv;
			vsel <= sv;
			src <= (src & ~(25'h1 << (n - 1))) | ((n < 24) ? 25'h1 << n : 25'h0);
		end
		coreEn <= 1'b0;
		$display("irq test done");
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		waitStrobe();
		`CHK("power-up", 14'h0000, addr[2])
		`CHK("busy", 1'b0, busy[2])
		t_table();
		t_reset();
		t_irq(4'h0);
		t_irq(4'h3);
		test_done();
	end
	initial begin
		#100us;
		fails++;
		test_done();
	end
endmodule // tb_top
